// ### inc/dmpc_pkg.sv
// Purpose: Constants and carrier types of the dual-mode pin control block.
// Assumes: One 200 MHz system clock samples every pin, the serial clock included.
// Notes: Register offsets are byte addresses on the plain register port.
package dmpc_pkg;

    // Serial frame geometry
    localparam int FRAME_BITS = 16;
    localparam int FRAME_CHECK_BITS = 24;
    localparam int CHECK_BITS = 8;
    localparam int COUNT_W = 5;
    localparam logic [COUNT_W-1:0] COUNT_PLAIN = 5'h10;
    localparam logic [COUNT_W-1:0] COUNT_CHECKED = 5'h18;
    localparam logic [COUNT_W-1:0] COUNT_MAX = 5'h1f;
    localparam logic [CHECK_BITS-1:0] CHECK_POLY = 8'h07;
    localparam logic [CHECK_BITS-1:0] CHECK_INIT = 8'h00;

    // Frame field positions
    localparam int FLD_ADDR_HI = 15;
    localparam int FLD_ADDR_LO = 13;
    localparam int FLD_CLEAR = 12;
    localparam int FLD_CLEAR_VALUE_SELECT = 11;
    localparam int FLD_RANGE_HI = 10;
    localparam int FLD_RANGE_LO = 7;
    localparam int FLD_DRIVE = 6;
    localparam int FLD_SENSE = 5;
    localparam int FLD_READBACK = 4;

    // Register map
    localparam int BUS_DW = 32;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_CONFIG = 8'h0c;
    localparam logic [7:0] OFS_PINS = 8'h10;

    // Status and mask bit positions
    localparam int STAT_W = 5;
    localparam int ST_LATCHED = 0;
    localparam int ST_CHECK_ERR = 1;
    localparam int ST_OPEN = 2;
    localparam int ST_HOT = 3;
    localparam int ST_BAD_LEN = 4;
    localparam logic [STAT_W-1:0] STAT_RESET = 5'h00;
    localparam logic [STAT_W-1:0] MASK_RESET = 5'h00;

    // Synchronised pin group
    typedef struct packed {
        logic sclk;
        logic serial_in_line;
        logic latch;
        logic addr2;
        logic addr1;
        logic addr0;
        logic clearPin;
        logic clrSelPin;
        logic hwSel;
        logic resetN;
        logic openCircuit;
        logic overTemp;
    } dmpc_pins_t;

    // Configuration loaded by a frame
    typedef struct packed {
        logic clearBit;
        logic clrSelBit;
        logic [3:0] range;
        logic driveEn;
        logic senseInternal;
    } dmpc_cfg_t;

    localparam dmpc_cfg_t CFG_RESET = '{default: 1'b0};

    // Registered top-level outputs
    typedef struct packed {
        logic sdo;
        logic faultOeN;
        logic openLoopOeN;
        logic [3:0] rangeSel;
        logic driveEn;
        logic senseInternal;
        logic clearActive;
        logic clearMid;
        logic irq;
        logic [BUS_DW-1:0] rdata;
    } dmpc_out_t;

endpackage

// ### verilog/dmpc_pin_ctrl.sv
// Purpose: Pin-level control of a single-channel current output driver.
// Assumes: All pins are asynchronous to clk and pass two flops first.
// Notes: The serial clock is oversampled, so its rate is bounded by clk.
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/10ps
module dmpc_pin_ctrl
    import dmpc_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock and chip reset
    input wire logic clk,
    input wire logic rst_n,
    // Shared serial and hardware-mode pins
    input wire logic serialClockPin,
    input wire logic serialInLine,
    input wire logic frameLatchStrobe,
    input wire logic addressPin2,
    input wire logic addressPin1,
    input wire logic addressPin0,
    // Mode, clear and reset pins
    input wire logic clearValueSelect,
    input wire logic clearPin,
    input wire logic controlSourceSelect,
    input wire logic resetPinN,
    // Analog fault detectors
    input wire logic openCircuitDet,
    input wire logic overTempDet,
    // Serial readback line
    output logic serialOutLine,
    // Open-drain fault pins
    output logic faultOut,
    output logic faultOeN,
    output logic openLoopAlertOut,
    output logic openLoopAlertOeN,
    // Controls to the analog path
    output logic [3:0] rangeSel,
    output logic outputDriveEnable,
    output logic senseResistorSelect,
    output logic clearActive,
    output logic clearMidscale,
    // Interrupt
    output logic irq,
    // Register port
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [BUS_DW-1:0] regWdata,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [BUS_DW-1:0] regRdata
);

    // Address must reach the highest offset
    initial begin
        if (ADDR_W < 5 || ADDR_W > 32) begin
            $error("ADDR_W must be 5 to 32");
        end
    end

    // Whole state of the block
    typedef struct packed {
        dmpc_pins_t s1;
        dmpc_pins_t s2;
        dmpc_pins_t prev;
        logic [FRAME_CHECK_BITS-1:0] shiftIn;
        logic [COUNT_W-1:0] bitCount;
        logic [FRAME_BITS-1:0] rbShift;
        dmpc_cfg_t cfg;
        logic checkErr;
        logic checkRequire;
        logic [STAT_W-1:0] status;
        logic [STAT_W-1:0] mask;
        dmpc_out_t out;
    } dmpc_state_t;

    localparam dmpc_state_t STATE_RESET = '{
        s1: '{default: 1'b0},
        s2: '{default: 1'b0},
        prev: '{default: 1'b0},
        shiftIn: '0,
        bitCount: '0,
        rbShift: '0,
        cfg: CFG_RESET,
        checkErr: 1'b0,
        checkRequire: 1'b0,
        status: STAT_RESET,
        mask: MASK_RESET,
        out: '{faultOeN: 1'b1, openLoopOeN: 1'b1, default: '0}
    };

    dmpc_state_t state_reg; // Registered state
    dmpc_state_t state_next; // Next state

    // Frame check over the data word, one bit at a time
    function automatic logic [CHECK_BITS-1:0] frameCheck(input logic [FRAME_BITS-1:0] word);
        logic [CHECK_BITS-1:0] crc;
        crc = CHECK_INIT;
        for (int i = FRAME_BITS - 1; i >= 0; i--) begin
            if (crc[CHECK_BITS-1] ^ word[i]) begin
                crc = {crc[CHECK_BITS-2:0], 1'b0} ^ CHECK_POLY;
            end else begin
                crc = {crc[CHECK_BITS-2:0], 1'b0};
            end
        end
        return crc;
    endfunction

    // Register offset compare on the whole address
    function automatic logic hitOfs(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return a == ADDR_W'(ofs);
    endfunction

    // Combinational helpers
    logic swMode; // Software control selected
    logic sclkRise; // Serial clock rising edge seen
    logic sclkFall; // Serial clock falling edge seen
    logic latchRise; // Latch strobe rising edge seen
    logic swReset; // Reset pin asserted in software mode
    logic [FRAME_BITS-1:0] word; // Data part of the received frame
    logic lenOk; // Frame length acceptable
    logic checkOk; // Frame check matched or not used
    logic addrOk; // Frame addressed to this device
    logic [STAT_W-1:0] events; // Event bits this cycle
    logic [STAT_W-1:0] w1c; // Bits cleared by software
    logic [FRAME_BITS-1:0] rbWord; // Readback word
    logic [BUS_DW-1:0] rdVal; // Decoded read value

    // Next-state logic
    always_comb begin
        state_next = state_reg;
        word = '0;
        lenOk = 1'b0;
        checkOk = 1'b0;
        addrOk = 1'b0;
        events = '0;
        w1c = '0;
        rdVal = '0;

        // Two-stage pin synchronisers
        state_next.s1 = '{
            sclk: serialClockPin,
            serial_in_line: serialInLine,
            latch: frameLatchStrobe,
            addr2: addressPin2,
            addr1: addressPin1,
            addr0: addressPin0,
            clearPin: clearPin,
            clrSelPin: clearValueSelect,
            hwSel: controlSourceSelect,
            resetN: resetPinN,
            openCircuit: openCircuitDet,
            overTemp: overTempDet
        };
        state_next.s2 = state_reg.s1;
        state_next.prev = state_reg.s2;

        // Mode from the second stage; edges compare the second stage with prev
        swMode = !state_reg.s2.hwSel;
        sclkRise = state_reg.s2.sclk && !state_reg.prev.sclk;
        sclkFall = !state_reg.s2.sclk && state_reg.prev.sclk;
        latchRise = state_reg.s2.latch && !state_reg.prev.latch;
        swReset = swMode && !state_reg.s2.resetN;

        // Readback word shows address, faults and configuration
        rbWord = {state_reg.s2.addr2, state_reg.s2.addr1, state_reg.s2.addr0,
                  state_reg.checkErr, state_reg.s2.openCircuit, state_reg.s2.overTemp,
                  state_reg.cfg.range, state_reg.cfg.driveEn, state_reg.cfg.senseInternal,
                  state_reg.cfg.clearBit, state_reg.cfg.clrSelBit, 2'h0};

        if (swReset) begin
            // Reset pin returns the link side to power-on state
            state_next.shiftIn = '0;
            state_next.bitCount = '0;
            state_next.rbShift = '0;
            state_next.cfg = CFG_RESET;
            state_next.checkErr = 1'b0;
        end else if (swMode) begin
            // Input bit taken at the serial clock fall
            if (sclkFall) begin
                state_next.shiftIn = {state_reg.shiftIn[FRAME_CHECK_BITS-2:0],
                                      state_reg.s2.serial_in_line};
                if (state_reg.bitCount != COUNT_MAX) begin
                    state_next.bitCount = state_reg.bitCount + 1'b1;
                end
            end
            // Readback moves one bit on the serial clock rise
            if (sclkRise) begin
                state_next.rbShift = {state_reg.rbShift[FRAME_BITS-2:0], 1'b0};
            end
            // Latch strobe rise closes the frame
            if (latchRise) begin
                if (state_reg.bitCount == COUNT_PLAIN) begin
                    word = state_reg.shiftIn[FRAME_BITS-1:0];
                    lenOk = !state_reg.checkRequire;
                    checkOk = 1'b1;
                end else if (state_reg.bitCount == COUNT_CHECKED) begin
                    word = state_reg.shiftIn[FRAME_CHECK_BITS-1:CHECK_BITS];
                    lenOk = 1'b1;
                    checkOk = frameCheck(word) == state_reg.shiftIn[CHECK_BITS-1:0];
                end
                addrOk = word[FLD_ADDR_HI:FLD_ADDR_LO] ==
                         {state_reg.s2.addr2, state_reg.s2.addr1, state_reg.s2.addr0};
                state_next.bitCount = '0;
                if (!lenOk) begin
                    events[ST_BAD_LEN] = 1'b1;
                end else if (!checkOk) begin
                    // Corrupt frame is dropped and flagged
                    events[ST_CHECK_ERR] = 1'b1;
                    state_next.checkErr = 1'b1;
                end else if (addrOk) begin
                    // Parallel load of the new settings
                    state_next.cfg.clearBit = word[FLD_CLEAR];
                    state_next.cfg.clrSelBit = word[FLD_CLEAR_VALUE_SELECT];
                    state_next.cfg.range = word[FLD_RANGE_HI:FLD_RANGE_LO];
                    state_next.cfg.driveEn = word[FLD_DRIVE];
                    state_next.cfg.senseInternal = word[FLD_SENSE];
                    state_next.checkErr = 1'b0;
                    events[ST_LATCHED] = 1'b1;
                    if (word[FLD_READBACK]) begin
                        state_next.rbShift = rbWord;
                    end
                end
            end
        end

        // Level faults keep their sticky bits set
        events[ST_OPEN] = state_reg.s2.openCircuit;
        events[ST_HOT] = state_reg.s2.overTemp;

        // Register writes
        if (regWrite) begin
            if (hitOfs(regAddr, OFS_CTRL)) begin
                state_next.checkRequire = regWdata[0];
            end
            if (hitOfs(regAddr, OFS_STATUS)) begin
                w1c = regWdata[STAT_W-1:0];
            end
            if (hitOfs(regAddr, OFS_MASK)) begin
                state_next.mask = regWdata[STAT_W-1:0];
            end
        end
        // A new event wins over a clear in the same cycle
        state_next.status = (state_reg.status & ~w1c) | events;

        // Register reads, data valid only the cycle after
        if (regRead) begin
            if (hitOfs(regAddr, OFS_CTRL)) begin
                rdVal = BUS_DW'(state_reg.checkRequire);
            end else if (hitOfs(regAddr, OFS_STATUS)) begin
                rdVal = BUS_DW'(state_reg.status);
            end else if (hitOfs(regAddr, OFS_MASK)) begin
                rdVal = BUS_DW'(state_reg.mask);
            end else if (hitOfs(regAddr, OFS_CONFIG)) begin
                rdVal = BUS_DW'(state_reg.cfg);
            end else if (hitOfs(regAddr, OFS_PINS)) begin
                rdVal = BUS_DW'({state_reg.checkErr, state_reg.s2.hwSel,
                                 state_reg.s2.addr2, state_reg.s2.addr1,
                                 state_reg.s2.addr0});
            end
        end
        state_next.out.rdata = rdVal;

        // Pin functions by mode
        if (swMode) begin
            state_next.out.sdo = state_next.rbShift[FRAME_BITS-1];
            state_next.out.rangeSel = state_next.cfg.range;
            state_next.out.driveEn = state_next.cfg.driveEn;
            state_next.out.senseInternal = state_next.cfg.senseInternal;
            state_next.out.clearActive = state_reg.s2.clearPin
                                         | state_next.cfg.clearBit;
            state_next.out.clearMid = state_reg.s2.clrSelPin
                                      | state_next.cfg.clrSelBit;
            state_next.out.faultOeN = !(state_reg.s2.openCircuit | state_reg.s2.overTemp
                                        | state_next.checkErr);
            state_next.out.openLoopOeN = 1'b1;
        end else begin
            state_next.out.sdo = 1'b0;
            state_next.out.rangeSel = {state_reg.s2.addr0, state_reg.s2.addr1,
                                       state_reg.s2.addr2, state_reg.s2.serial_in_line};
            state_next.out.driveEn = state_reg.s2.sclk;
            state_next.out.senseInternal = state_reg.s2.latch;
            state_next.out.clearActive = state_reg.s2.clearPin;
            state_next.out.clearMid = state_reg.s2.clrSelPin;
            state_next.out.faultOeN = !state_reg.s2.overTemp;
            state_next.out.openLoopOeN = !state_reg.s2.openCircuit;
        end

        // Level interrupt from unmasked sticky bits
        state_next.out.irq = |(state_next.status & state_next.mask);
    end

    // State register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flops; the open-drain data pins are tied low
    assign serialOutLine = state_reg.out.sdo;
    assign faultOut = 1'b0;
    assign faultOeN = state_reg.out.faultOeN;
    assign openLoopAlertOut = 1'b0;
    assign openLoopAlertOeN = state_reg.out.openLoopOeN;
    assign rangeSel = state_reg.out.rangeSel;
    assign outputDriveEnable = state_reg.out.driveEn;
    assign senseResistorSelect = state_reg.out.senseInternal;
    assign clearActive = state_reg.out.clearActive;
    assign clearMidscale = state_reg.out.clearMid;
    assign irq = state_reg.out.irq;
    assign regRdata = state_reg.out.rdata;

endmodule

// ### testbench/dmpc_pin_ctrl_properties.sv
// Purpose: Port-level checks of the pin control block.
// Assumes: The bench changes pins only right after clk rising edges.
// Notes: Pin-follow checks need a pin steady across the sync delay.
`timescale 1ns/10ps
module dmpc_pin_ctrl_properties
    import dmpc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins in
    input wire logic controlSourceSelect,
    input wire logic openCircuitDet,
    input wire logic overTempDet,
    input wire logic clearPin,
    input wire logic serialInLine,
    input wire logic addressPin2,
    input wire logic addressPin1,
    input wire logic addressPin0,
    input wire logic frameLatchStrobe,
    input wire logic serialClockPin,
    // Pins out
    input wire logic faultOeN,
    input wire logic openLoopAlertOeN,
    input wire logic [3:0] rangeSel,
    input wire logic outputDriveEnable,
    input wire logic senseResistorSelect,
    input wire logic clearActive
);
    logic [9:0] pinVec, st, v; // Order: hw open hot clr serial_in_line a2 a1 a0 latch sclk
    logic [39:0] histReg; // Four past samples of pinVec
    logic [2:0] ageReg; // Edges since reset, saturating
    logic hwOk, swOk; // Mode steady and synchronisers refilled
    assign pinVec = {controlSourceSelect, openCircuitDet, overTempDet, clearPin, serialInLine,
        addressPin2, addressPin1, addressPin0, frameLatchStrobe, serialClockPin};
    assign v = histReg[29:20];
    assign st = ~(histReg[19:10] ^ v) & ~(histReg[39:30] ^ v);
    assign hwOk = (ageReg == 3'h7) && st[9] && v[9];
    assign swOk = (ageReg == 3'h7) && st[9] && !v[9];
    // Pin history covering the sync delay
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            histReg <= '0;
            ageReg <= 3'h0;
        end else begin
            histReg <= {histReg[29:0], pinVec};
            ageReg <= ageReg + {2'h0, ageReg != 3'h7};
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_HW_OPEN_LOOP: assert property (hwOk && st[8] |-> openLoopAlertOeN == !v[8])
        else $error("open loop alert does not follow detector");
    AST_HW_HOT_ONLY: assert property (hwOk && st[7] |-> faultOeN == !v[7])
        else $error("fault pin does not follow overtemperature");
    AST_SW_OPEN_IDLE: assert property (swOk |-> openLoopAlertOeN [*2])
        else $error("open loop alert pulled in software mode");
    AST_SW_FAULT_PULL: assert property (swOk && (st[8] && v[8] || st[7] && v[7]) |-> !faultOeN)
        else $error("fault pin released during a fault");
    AST_HW_RANGE: assert property (hwOk && (&st[5:2]) |-> rangeSel == {v[2], v[3], v[4], v[5]})
        else $error("range does not follow range pins");
    AST_HW_SENSE: assert property (hwOk && st[1] |-> senseResistorSelect == v[1])
        else $error("sense select does not follow pin");
    AST_HW_DRIVE: assert property (hwOk && st[0] |-> (outputDriveEnable == v[0]) [*2])
        else $error("drive enable does not follow pin");
    AST_CLEAR_PIN: assert property ((ageReg == 3'h7) && st[6] && v[6] |-> clearActive)
        else $error("clear pin high but clear inactive");
    cover property (hwOk && !openLoopAlertOeN);
    cover property (swOk && !faultOeN);
    cover property (hwOk && rangeSel == 4'hf);
endmodule
bind dmpc_pin_ctrl dmpc_pin_ctrl_properties u_props (
    .clk(clk), .rst_n(rst_n), .controlSourceSelect(controlSourceSelect),
    .openCircuitDet(openCircuitDet), .overTempDet(overTempDet), .clearPin(clearPin),
    .serialInLine(serialInLine), .addressPin2(addressPin2), .addressPin1(addressPin1),
    .addressPin0(addressPin0), .frameLatchStrobe(frameLatchStrobe),
    .serialClockPin(serialClockPin), .faultOeN(faultOeN), .openLoopAlertOeN(openLoopAlertOeN),
    .rangeSel(rangeSel), .outputDriveEnable(outputDriveEnable),
    .senseResistorSelect(senseResistorSelect), .clearActive(clearActive));

// ### testbench/dmpc_host_model.sv
// Purpose: Host side of the serial link, driven by bench calls.
// Assumes: clk runs at 200 MHz; the link clock period is 80 ns.
// Notes: Readback is captured just before each rising edge.
`timescale 1ns/10ps
module dmpc_host_model (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic serialClockPin,
    output logic serialInLine,
    output logic frameLatchStrobe,
    input wire logic serialOutLine
);
    logic [15:0] rbWord = 16'h0000; // Last sixteen readback bits
    // Idle levels at time zero
    initial begin
        serialClockPin = 1'b0;
        serialInLine = 1'b0;
        frameLatchStrobe = 1'b0;
    end
    // Shift a frame MSB first, then latch it
    task automatic sendFrame(input logic [23:0] word, input int bits);
        for (int i = 0; i < bits; i++) begin
            @(posedge clk);
            rbWord <= {rbWord[14:0], serialOutLine};
            serialInLine <= word[bits-1-i];
            serialClockPin <= 1'b1;
            repeat (8) @(posedge clk);
            serialClockPin <= 1'b0;
            repeat (7) @(posedge clk);
        end
        @(posedge clk);
        frameLatchStrobe <= 1'b1;
        repeat (8) @(posedge clk);
        frameLatchStrobe <= 1'b0;
    endtask
    // Static levels for hardware mode
    task automatic setPins(input logic ck, input logic din, input logic lat);
        @(posedge clk);
        serialClockPin <= ck;
        serialInLine <= din;
        frameLatchStrobe <= lat;
    endtask
endmodule

// ### testbench/tb_dual_mode_pin_control_interface.sv
// Purpose: Self-checking bench of the pin control block.
// Assumes: The host model moves the serial pins; the bench moves the rest.
// Notes: Expected values follow the frame layout and register map.
`timescale 1ns/10ps
module tb_dual_mode_pin_control_interface;
    import dmpc_pkg::*;
    logic clk, rst_n, sclk, serial_in_line, latch, sdo, a2, a1, a0, clear_value_select, clrPin, hwSel, resetN;
    logic openDet, hotDet, regWrite, regRead, faultOeN, openOeN, drive, sense, clrAct, clrMid, irq;
    logic [7:0] regAddr;
    logic [31:0] regWdata, regRdata;
    logic [3:0] rangeSel;
    logic [15:0] w; // Frame word under test
    int errCount = 0;
    int checks = 0;
    int cycles = 0;
    dmpc_host_model u_host (.clk(clk), .serialClockPin(sclk), .serialInLine(serial_in_line),
        .frameLatchStrobe(latch), .serialOutLine(sdo));
    dmpc_pin_ctrl #(.ADDR_W(8)) u_dut (.clk(clk), .rst_n(rst_n), .serialClockPin(sclk),
        .serialInLine(serial_in_line), .frameLatchStrobe(latch), .addressPin2(a2), .addressPin1(a1),
        .addressPin0(a0), .clearValueSelect(clear_value_select), .clearPin(clrPin),
        .controlSourceSelect(hwSel), .resetPinN(resetN), .openCircuitDet(openDet),
        .overTempDet(hotDet), .serialOutLine(sdo), .faultOut(), .faultOeN(faultOeN),
        .openLoopAlertOut(), .openLoopAlertOeN(openOeN), .rangeSel(rangeSel),
        .outputDriveEnable(drive), .senseResistorSelect(sense), .clearActive(clrAct),
        .clearMidscale(clrMid), .irq(irq), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
    // Clock of 5 ns period
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            errCount++;
            test_done();
        end
    end
    task automatic test_done;
        $display("checks %0d mismatches %0d", checks, errCount);
        if (errCount == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            errCount++;
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1 chk(regRdata, e);
    endtask
    // Frame word: address, settings byte, readback request
    function automatic logic [15:0] fw(input logic [2:0] ad, input logic [7:0] cfg, input logic rb);
        return {ad, cfg, rb, 4'h0};
    endfunction
    // Check byte, MSB first
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ 8'h07) : {c[6:0], 1'b0};
        end
        return c;
    endfunction
    // Main sequence
    initial begin
        rst_n = 1'b0;
        {a2, a1, a0, clear_value_select, clrPin, hwSel, openDet, hotDet} = 8'h00;
        resetN = 1'b1;
        {regWrite, regRead, regAddr, regWdata} = '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFS_STATUS, 32'h0);
        rd(OFS_CONFIG, 32'h0);
        rd(8'h14, 32'h0);
        wr(OFS_MASK, 32'h1);
        u_host.sendFrame({8'h00, fw(3'h0, 8'h2b, 1'b0)}, 16);
        settle(1);
        chk({irq, drive, sense, rangeSel}, 7'h7a);
        rd(OFS_CONFIG, 32'h2b);
        wr(OFS_STATUS, 32'h1);
        settle(2);
        chk(irq, 1'b0);
        u_host.sendFrame({8'h00, fw(3'h0, 8'h2b, 1'b1)}, 16);
        u_host.sendFrame({8'h00, fw(3'h0, 8'hd4, 1'b0)}, 16);
        settle(1);
        chk(u_host.rbWord, 16'h02b0);
        chk({clrAct, clrMid, irq, rangeSel}, 7'h75);
        wr(OFS_MASK, 32'h0);
        settle(2);
        chk(irq, 1'b0);
        @(posedge clk);
        {a2, a1, a0} <= 3'h5;
        u_host.sendFrame({8'h00, fw(3'h0, 8'h0c, 1'b0)}, 16);
        settle(1);
        chk(rangeSel, 4'h5);
        u_host.sendFrame({8'h00, fw(3'h5, 8'h0e, 1'b0)}, 16);
        settle(1);
        chk({clrAct, rangeSel}, 5'h03);
        w = fw(3'h5, 8'h1f, 1'b0);
        u_host.sendFrame({w, crc8(w)}, 24);
        settle(1);
        chk(rangeSel, 4'h7);
        wr(OFS_STATUS, 32'h1f);
        w = fw(3'h5, 8'h27, 1'b0);
        u_host.sendFrame({w, ~crc8(w)}, 24);
        settle(1);
        chk({faultOeN, rangeSel}, 5'h07);
        rd(OFS_STATUS, 32'h2);
        u_host.sendFrame({w, crc8(w)}, 24);
        settle(1);
        chk({faultOeN, rangeSel}, 5'h19);
        wr(OFS_STATUS, 32'h1f);
        u_host.sendFrame({8'h00, w}, 15);
        wr(OFS_CTRL, 32'h1);
        u_host.sendFrame({8'h00, fw(3'h5, 8'h0e, 1'b0)}, 16);
        settle(1);
        chk(rangeSel, 4'h9);
        wr(OFS_CTRL, 32'h0);
        @(posedge clk);
        openDet <= 1'b1;
        settle(5);
        chk({faultOeN, openOeN}, 2'h1);
        rd(OFS_STATUS, 32'h14);
        @(posedge clk);
        openDet <= 1'b0;
        resetN <= 1'b0;
        settle(10);
        chk({drive, sense, rangeSel}, 6'h00);
        @(posedge clk);
        resetN <= 1'b1;
        hwSel <= 1'b1;
        // Hardware mode: each pin pattern maps straight to the controls
        for (int r = 0; r < 16; r++) begin
            u_host.setPins(r[0] ^ r[1], r[0], r[2]);
            {a2, a1, a0} <= {r[1], r[2], r[3]};
            settle(5);
            chk({drive, sense, rangeSel}, {r[0] ^ r[1], r[2], r[3:0]});
        end
        @(posedge clk);
        hotDet <= 1'b1;
        settle(5);
        chk({faultOeN, openOeN}, 2'h1);
        @(posedge clk);
        hotDet <= 1'b0;
        openDet <= 1'b1;
        resetN <= 1'b0;
        clrPin <= 1'b1;
        clear_value_select <= 1'b1;
        settle(5);
        chk({faultOeN, openOeN, clrAct, clrMid, rangeSel}, 8'hbf);
        test_done();
    end
endmodule
